// ---- hdl/afmas_pkg.sv ----
package afmas_pkg;
	// register word addresses on the slave port
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_ACTION_MAP = 4'h1;
	localparam logic [3:0] ADDR_ENC_CPT = 4'h2;
	localparam logic [3:0] ADDR_UNITS_PER_TURN = 4'h3;
	localparam logic [3:0] ADDR_STEP_LIMIT = 4'h4;
	localparam logic [3:0] ADDR_COMP_WINDOW = 4'h5;
	localparam logic [3:0] ADDR_INPOS_WINDOW = 4'h6;
	localparam logic [3:0] ADDR_FOLLOW_WINDOW = 4'h7;
	localparam logic [3:0] ADDR_TARGET_POS = 4'h8;
	localparam logic [3:0] ADDR_COMMAND_POS = 4'h9;
	localparam logic [3:0] ADDR_ACTUAL_POS = 4'ha;
	localparam logic [3:0] ADDR_STATUS = 4'hb;
	localparam logic [3:0] ADDR_ACTIVE_MAP = 4'hc;
	// control register write bits
	localparam int CTL_APPLY = 0;
	localparam int CTL_AMP_ENABLE = 1;
	localparam int CTL_CLOSED_LOOP = 2;
	localparam int CTL_MOVING = 3;
	localparam int CTL_CLEAR_HALT = 4;
	// status bits
	localparam int ST_IN_POS = 0;
	localparam int ST_HALT = 1;
	localparam int ST_OPEN_LOOP = 2;
	localparam int ST_AMP_ON = 3;
	localparam int ST_COMP_ACTIVE = 4;
	localparam int ST_ERR_LSB = 8;
	// fault indices
	localparam int F_FOLLOW = 0;
	localparam int F_POS_OVF = 2;
	localparam int F_OVERDRIVE = 4;
	localparam int F_XDCR_OVF = 5;
	localparam int F_XDCR_NOISE = 6;
	localparam int F_ENC_FAULT = 7;
	localparam int NFAULT = 8;
	localparam int MAP_SOFT_LSB = 8;
	// reset values
	localparam logic [15:0] MAP_RESET = 16'h1fe0;
	localparam logic [15:0] ENC_CPT_RESET = 16'h0001;
	localparam logic [15:0] UNITS_RESET = 16'h0001;
	localparam logic [10:0] STEP_LIMIT_RESET = 11'h400;
	localparam logic [15:0] COMP_WINDOW_RESET = 16'h0064;
	localparam logic [15:0] INPOS_RESET = 16'h0032;
	localparam logic [15:0] FOLLOW_RESET = 16'h00fa;
	localparam logic [31:0] DIV_ZERO_GUARD = 32'h0000_0001;
	// fault actions, hard bit then soft bit
	typedef enum logic [1:0] {
		AFMAS_ACT_STATUS = 2'b00,
		AFMAS_ACT_SOFT = 2'b01,
		AFMAS_ACT_HARD = 2'b10,
		AFMAS_ACT_DISABLE = 2'b11
	} afmas_action_e;
endpackage

// ---- hdl/afmas_top.sv ----
`timescale 1ns/10ps
// Function
// - encoder counts-per-turn of zero makes actual position follow target.
// - sign of counts-per-turn sets direction of encoder counting.
// - each loop add count change times units-per-turn over counts-per-turn.
// - requested steps above the step-rate limit set the overdrive error.
// - stationary axis compensates only outside the in-position window.
// - moving axis compensates only when error exceeds the compensation window.
// - in-position bit set while strictly inside window, never latched.
// - following error set when target minus actual exceeds its window.
// - stop actions trigger on rising edges of the eight error bits.
// - action map resets to 0x1FE0.
// - open loop triggers no automatic stop action.
// - fault index order: following 0, position overflow 2, overdrive 4, transducer overflow 5, transducer noise 6, encoder 7.
// - status-only action just reports the fault.
// - soft stop ramps down, stops sequences and sets halt.
// - feedback faults use the open-loop ramp for soft stops.
// - hard stop zeroes drive, opens loop, stops sequences, sets flags.
// - stops in open loop leave the drive output untouched.
// - disable drive hard stops and opens amp enable until commanded.
// - fault n owns soft bit 8+n and hard bit n.
// - hard,soft decode: 00 status, 01 soft, 10 hard, 11 disable.
// - illegal status-only becomes soft; disable without amp becomes hard.
// - written map takes effect only at the apply-parameters command.
// - both bits set gives hard stop plus amp enable opened.
module afmas_top
	import afmas_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// avalon-mm slave
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// control loop
	input wire logic LOOP_TICK,
	input wire logic signed [31:0] ENCODER_COUNT,
	input wire logic signed [15:0] STEP_REQUEST,
	input wire logic [7:0] EXT_FAULTS,
	// drive side
	output logic HALT_SOFT_RAMP,
	output logic HALT_OPEN_RAMP,
	output logic DRIVE_ZERO,
	output logic SEQUENCE_STOP,
	output logic AMP_ENABLE,
	output logic COMP_APPLY
);
	import afmas_pkg::*;

	logic [15:0] map_staged_reg, map_active_reg;
	logic signed [15:0] enc_cpt_reg;
	logic [15:0] units_reg, comp_win_reg, inpos_reg, follow_reg;
	logic [10:0] step_limit_reg;
	logic signed [31:0] target_reg, command_reg, actual_reg;
	logic signed [31:0] last_count_reg;
	logic closed_reg, moving_reg, halt_reg, amp_reg;
	logic [7:0] err_reg, err_prev_reg;
	logic inpos_reg_bit, comp_reg;
	logic soft_reg, open_ramp_reg, zero_reg, seq_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;

	logic req;
	assign req = (AVS_READ | AVS_WRITE) & ~ack_reg;
	assign AVS_WAITREQUEST = req;
	assign AVS_READDATA = rdata_reg;

	always_ff @(posedge CORE_CLK) begin
		if (SRST)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	logic wr;
	assign wr = AVS_WRITE & ack_reg;

	// parameter registers
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			map_staged_reg <= MAP_RESET;
			enc_cpt_reg <= ENC_CPT_RESET;
			units_reg <= UNITS_RESET;
			step_limit_reg <= STEP_LIMIT_RESET;
			comp_win_reg <= COMP_WINDOW_RESET;
			inpos_reg <= INPOS_RESET;
			follow_reg <= FOLLOW_RESET;
			target_reg <= '0;
			command_reg <= '0;
		end else if (wr) begin
			case (AVS_ADDRESS)
			ADDR_ACTION_MAP: map_staged_reg <= AVS_WRITEDATA[15:0];
			ADDR_ENC_CPT: enc_cpt_reg <= AVS_WRITEDATA[15:0];
			ADDR_UNITS_PER_TURN: units_reg <= AVS_WRITEDATA[15:0];
			ADDR_STEP_LIMIT: step_limit_reg <= AVS_WRITEDATA[10:0];
			ADDR_COMP_WINDOW: comp_win_reg <= AVS_WRITEDATA[15:0];
			ADDR_INPOS_WINDOW: inpos_reg <= AVS_WRITEDATA[15:0];
			ADDR_FOLLOW_WINDOW: follow_reg <= AVS_WRITEDATA[15:0];
			ADDR_TARGET_POS: target_reg <= AVS_WRITEDATA;
			ADDR_COMMAND_POS: command_reg <= AVS_WRITEDATA;
			default: ;
			endcase
		end
	end

	logic ctl_wr;
	assign ctl_wr = wr && AVS_ADDRESS == ADDR_CONTROL;

	// active map only changes on apply
	always_ff @(posedge CORE_CLK) begin
		if (SRST)
			map_active_reg <= MAP_RESET;
		else if (ctl_wr && AVS_WRITEDATA[CTL_APPLY])
			map_active_reg <= map_staged_reg;
	end

	// position scaling
	logic signed [31:0] delta_cnt;
	logic signed [47:0] scaled;
	logic signed [31:0] step_pos;
	logic signed [31:0] divisor;
	assign delta_cnt = ENCODER_COUNT - last_count_reg;
	assign divisor = (enc_cpt_reg == '0) ? DIV_ZERO_GUARD
		: 32'(enc_cpt_reg);
	// signed divisor flips direction for negative settings
	assign scaled = (48'(delta_cnt) * $signed({16'h0000, units_reg}))
		/ 48'(divisor);
	assign step_pos = 32'(scaled);

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			actual_reg <= '0;
			last_count_reg <= '0;
		end else if (LOOP_TICK) begin
			last_count_reg <= ENCODER_COUNT;
			if (enc_cpt_reg == '0)
				actual_reg <= target_reg;
			else
				actual_reg <= actual_reg + step_pos;
		end
	end

	// window comparisons
	logic signed [32:0] follow_diff, cmd_diff;
	logic [32:0] follow_mag, cmd_mag;
	assign follow_diff = 33'(target_reg) - 33'(actual_reg);
	assign cmd_diff = 33'(command_reg) - 33'(actual_reg);
	assign follow_mag = follow_diff[32] ? 33'(-follow_diff) : follow_diff;
	assign cmd_mag = cmd_diff[32] ? 33'(-cmd_diff) : cmd_diff;

	logic in_win, follow_err, overdrive, comp_need;
	logic [15:0] step_mag;
	assign in_win = cmd_mag < 33'(inpos_reg);
	assign follow_err = follow_mag > 33'(follow_reg);
	assign step_mag = STEP_REQUEST[15] ? 16'(-STEP_REQUEST) : STEP_REQUEST;
	assign overdrive = step_mag > 16'(step_limit_reg);
	assign comp_need = moving_reg ? (follow_mag > 33'(comp_win_reg))
		: (follow_mag >= 33'(inpos_reg));

	// fault pins come from outside the clock domain: three stages,
	// a new level is taken only once stages two and three agree
	logic [7:0] flt_s1_reg, flt_s2_reg, flt_s3_reg, flt_reg;
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			flt_s1_reg <= '0;
			flt_s2_reg <= '0;
			flt_s3_reg <= '0;
			flt_reg <= '0;
		end else begin
			flt_s1_reg <= EXT_FAULTS;
			flt_s2_reg <= flt_s1_reg;
			flt_s3_reg <= flt_s2_reg;
			// both high sets, both low clears, disagreement holds
			flt_reg <= (flt_s2_reg & flt_s3_reg)
				| (flt_reg & (flt_s2_reg | flt_s3_reg));
		end
	end

	// error word: external faults plus locally found ones
	logic [7:0] err_now;
	always_comb begin
		err_now = flt_reg;
		err_now[F_FOLLOW] = flt_reg[F_FOLLOW] | follow_err;
		err_now[F_OVERDRIVE] = flt_reg[F_OVERDRIVE] | overdrive;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			err_reg <= '0;
			err_prev_reg <= '0;
			inpos_reg_bit <= 1'b0;
			comp_reg <= 1'b0;
		end else if (LOOP_TICK) begin
			err_prev_reg <= err_reg;
			err_reg <= err_now;
			inpos_reg_bit <= in_win;
			comp_reg <= comp_need;
		end
	end

	// per-fault action decode
	logic [7:0] rise, f_soft, f_hard, f_dis, f_open;
	genvar g;
	generate
		for (g = 0; g < NFAULT; g++) begin : g_fault
			afmas_action_e act;
			assign act = afmas_action_e'({map_active_reg[g],
				map_active_reg[MAP_SOFT_LSB + g]});
			logic no_status;
			// transducer faults cannot be status-only
			assign no_status = (g == F_ENC_FAULT) || (g == F_XDCR_NOISE)
				|| (g == F_XDCR_OVF);
			assign rise[g] = err_reg[g] & ~err_prev_reg[g];
			assign f_soft[g] = rise[g] && (act == AFMAS_ACT_SOFT
				|| (act == AFMAS_ACT_STATUS && no_status));
			assign f_hard[g] = rise[g] && (act == AFMAS_ACT_HARD
				|| act == AFMAS_ACT_DISABLE);
			assign f_dis[g] = rise[g] && act == AFMAS_ACT_DISABLE;
			assign f_open[g] = (g == F_POS_OVF) || (g == F_ENC_FAULT)
				|| (g == F_XDCR_OVF) || (g == F_XDCR_NOISE);
		end
	endgenerate

	logic any_soft, any_hard, any_dis, any_open;
	logic act_en;
	assign act_en = LOOP_TICK & closed_reg;
	assign any_soft = act_en & |f_soft;
	assign any_hard = act_en & |f_hard;
	assign any_dis = act_en & |f_dis;
	assign any_open = |(f_soft & f_open);

	// loop state and stop outputs
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			closed_reg <= 1'b0;
			moving_reg <= 1'b0;
			halt_reg <= 1'b0;
		end else begin
			if (ctl_wr) begin
				closed_reg <= AVS_WRITEDATA[CTL_CLOSED_LOOP];
				moving_reg <= AVS_WRITEDATA[CTL_MOVING];
				if (AVS_WRITEDATA[CTL_CLEAR_HALT])
					halt_reg <= 1'b0;
			end
			if (any_hard)
				closed_reg <= 1'b0;
			if (any_soft | any_hard)
				halt_reg <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST)
			amp_reg <= 1'b0;
		else if (any_dis)
			amp_reg <= 1'b0;
		else if (ctl_wr && AVS_WRITEDATA[CTL_AMP_ENABLE])
			amp_reg <= 1'b1;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			soft_reg <= 1'b0;
			open_ramp_reg <= 1'b0;
			zero_reg <= 1'b0;
			seq_reg <= 1'b0;
		end else begin
			soft_reg <= any_soft & ~any_hard & ~any_open;
			open_ramp_reg <= any_soft & ~any_hard & any_open;
			zero_reg <= any_hard;
			seq_reg <= any_soft | any_hard;
		end
	end

	assign HALT_SOFT_RAMP = soft_reg;
	assign HALT_OPEN_RAMP = open_ramp_reg;
	assign DRIVE_ZERO = zero_reg;
	assign SEQUENCE_STOP = seq_reg;
	assign AMP_ENABLE = amp_reg;
	assign COMP_APPLY = comp_reg;

	// read mux
	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[ST_IN_POS] = inpos_reg_bit;
		status_word[ST_HALT] = halt_reg;
		status_word[ST_OPEN_LOOP] = ~closed_reg;
		status_word[ST_AMP_ON] = amp_reg;
		status_word[ST_COMP_ACTIVE] = comp_reg;
		status_word[ST_ERR_LSB +: NFAULT] = err_reg;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST)
			rdata_reg <= '0;
		else if (AVS_READ & req) begin
			case (AVS_ADDRESS)
			ADDR_CONTROL: rdata_reg <= {28'h000_0000, moving_reg,
				closed_reg, amp_reg, 1'b0};
			ADDR_ACTION_MAP: rdata_reg <= {16'h0000, map_staged_reg};
			ADDR_ENC_CPT: rdata_reg <= 32'(enc_cpt_reg);
			ADDR_UNITS_PER_TURN: rdata_reg <= {16'h0000, units_reg};
			ADDR_STEP_LIMIT: rdata_reg <= {21'h00_0000, step_limit_reg};
			ADDR_COMP_WINDOW: rdata_reg <= {16'h0000, comp_win_reg};
			ADDR_INPOS_WINDOW: rdata_reg <= {16'h0000, inpos_reg};
			ADDR_FOLLOW_WINDOW: rdata_reg <= {16'h0000, follow_reg};
			ADDR_TARGET_POS: rdata_reg <= target_reg;
			ADDR_COMMAND_POS: rdata_reg <= command_reg;
			ADDR_ACTUAL_POS: rdata_reg <= actual_reg;
			ADDR_STATUS: rdata_reg <= status_word;
			ADDR_ACTIVE_MAP: rdata_reg <= {16'h0000, map_active_reg};
			default: rdata_reg <= '0;
			endcase
		end
	end
endmodule

// ---- testbench/afmas_drive_model.sv ----
`timescale 1ns/10ps
module afmas_drive_model (
	// loop side
	input wire logic clk,
	input wire logic srst,
	input wire logic tick,
	input wire logic clr,
	input wire logic signed [15:0] move,
	// stop pulses from the block
	input wire logic halt_soft,
	input wire logic halt_open,
	input wire logic drive_zero,
	input wire logic seq_stop,
	// encoder and pulse tallies
	output logic signed [31:0] enc_count,
	output logic [7:0] tally
);
	// shaft moves once per loop
	always_ff @(posedge clk) begin
		if (srst)
			enc_count <= 32'h0000_0000;
		else if (tick)
			enc_count <= enc_count + 32'(move);
	end
	always_ff @(posedge clk) begin
		if (srst || clr)
			tally <= 8'h00;
		else
			tally <= tally + {1'b0, halt_soft, 1'b0, halt_open,
				1'b0, drive_zero, 1'b0, seq_stop};
	end
endmodule

// ---- testbench/afmas_properties.sv ----
`timescale 1ns/10ps
module afmas_checker
	import afmas_pkg::*;
(
	// clock, reset, bus
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	// loop and drive
	input wire logic LOOP_TICK,
	input wire logic HALT_SOFT_RAMP,
	input wire logic HALT_OPEN_RAMP,
	input wire logic DRIVE_ZERO,
	input wire logic SEQUENCE_STOP,
	input wire logic AMP_ENABLE,
	input wire logic COMP_APPLY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	sequence stop_pulse;
		SEQUENCE_STOP ##1 !SEQUENCE_STOP;
	endsequence
	sequence after_tick;
		$past(LOOP_TICK);
	endsequence
	soft_stop_a:
		assert property (HALT_SOFT_RAMP || HALT_OPEN_RAMP |-> stop_pulse)
		else $error("soft stop lacks sequence stop");
	hard_stop_a: assert property (DRIVE_ZERO |-> stop_pulse)
		else $error("hard stop lacks sequence stop");
	hard_wins_a:
		assert property (DRIVE_ZERO |-> !(HALT_SOFT_RAMP || HALT_OPEN_RAMP))
		else $error("hard and soft stop together");
	stop_tick_a: assert property (SEQUENCE_STOP |-> after_tick)
		else $error("stop pulse not after loop tick");
	open_quiet_a: assert property (DRIVE_ZERO |=> !SEQUENCE_STOP[*3])
		else $error("stop pulse while in open loop");
	amp_on_a: assert property ($rose(AMP_ENABLE) |->
		$past(AVS_WRITE && AVS_ADDRESS == ADDR_CONTROL &&
		AVS_WRITEDATA[CTL_AMP_ENABLE])) else $error("amp enabled uncommanded");
	amp_off_a: assert property ($fell(AMP_ENABLE) |->
		DRIVE_ZERO || $past(DRIVE_ZERO) || $past(AVS_WRITE))
		else $error("amp dropped without cause");
	comp_tick_a: assert property ($changed(COMP_APPLY) |-> after_tick)
		else $error("compensation changed off tick");
endmodule
bind afmas_top afmas_checker u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .LOOP_TICK(LOOP_TICK),
	.HALT_SOFT_RAMP(HALT_SOFT_RAMP), .HALT_OPEN_RAMP(HALT_OPEN_RAMP),
	.DRIVE_ZERO(DRIVE_ZERO), .SEQUENCE_STOP(SEQUENCE_STOP),
	.AMP_ENABLE(AMP_ENABLE), .COMP_APPLY(COMP_APPLY));

// ---- testbench/afmas_tb_top.sv ----
`timescale 1ns/10ps
module afmas_tb_top;
	import afmas_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic tick = 1'b0;
	logic clr = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0000_0000;
	logic signed [15:0] step = 16'h0000;
	logic signed [15:0] mv = 16'h0000;
	logic [7:0] flt = 8'h00;
	logic [31:0] rdata, rdat, a;
	logic wreq, hs, ho, dz, ss, amp, comp;
	logic signed [31:0] enc;
	logic [7:0] tally;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	afmas_top DUT (.CORE_CLK(clk), .SRST(srst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .LOOP_TICK(tick),
		.ENCODER_COUNT(enc), .STEP_REQUEST(step), .EXT_FAULTS(flt),
		.HALT_SOFT_RAMP(hs), .HALT_OPEN_RAMP(ho), .DRIVE_ZERO(dz),
		.SEQUENCE_STOP(ss), .AMP_ENABLE(amp), .COMP_APPLY(comp));
	afmas_drive_model u_far (.clk(clk), .srst(srst), .tick(tick),
		.clr(clr), .move(mv), .halt_soft(hs), .halt_open(ho),
		.drive_zero(dz), .seq_stop(ss), .enc_count(enc), .tally(tally));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= ad;
		wd <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		rdat = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task wrr(input logic [3:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask
	task rdr(input logic [3:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h0000_0000);
		chk(rdat, e);
	endtask
	task ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask
	task t_scale;
		rdr(ADDR_ACTION_MAP, 32'h0000_1fe0);
		rdr(ADDR_ACTIVE_MAP, 32'h0000_1fe0);
		rdr(4'hd, 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			wrr(ADDR_ENC_CPT, k ? 32'h0000_fffc : 32'h0000_0004);
			wrr(ADDR_UNITS_PER_TURN, 32'h0000_000a);
			ticks(2);
			bus(1'b0, ADDR_ACTUAL_POS, 32'h0000_0000);
			a = rdat + (k ? 32'hffff_ffec : 32'h0000_0014);
			mv <= 16'h0008;
			ticks(1);
			mv <= 16'h0000;
			ticks(2);
			rdr(ADDR_ACTUAL_POS, a);
		end
		wrr(ADDR_ENC_CPT, 32'h0000_0000);
		wrr(ADDR_TARGET_POS, 32'h0000_04d2);
		ticks(2);
		rdr(ADDR_ACTUAL_POS, 32'h0000_04d2);
		$display("scaling test done");
	endtask
	task t_window;
		logic [15:0] offs [6];
		logic [5:0] ce;
		offs = '{16'h0031, 16'h0032, 16'h0064, 16'h0065, 16'h00fa, 16'h00fb};
		ce = 6'h3a;
		wrr(ADDR_ENC_CPT, 32'h0000_0001);
		wrr(ADDR_UNITS_PER_TURN, 32'h0000_0001);
		ticks(2);
		bus(1'b0, ADDR_ACTUAL_POS, 32'h0000_0000);
		a = rdat;
		for (int i = 0; i < 6; i++) begin
			wrr(ADDR_CONTROL, i > 1 ? 32'h0000_0008 : 32'h0000_0000);
			wrr(ADDR_TARGET_POS, a + 32'(offs[i]));
			wrr(ADDR_COMMAND_POS, a - 32'(offs[i]));
			ticks(2);
			bus(1'b0, ADDR_STATUS, 32'h0000_0000);
			chk(32'({rdat[ST_ERR_LSB], rdat[ST_COMP_ACTIVE],
				rdat[ST_IN_POS], comp}), 32'({i == 5, ce[i], i == 0, ce[i]}));
		end
		wrr(ADDR_CONTROL, 32'h0000_0000);
		wrr(ADDR_TARGET_POS, a);
		wrr(ADDR_STEP_LIMIT, 32'h0000_0064);
		for (int s = 0; s < 2; s++) begin
			step <= 16'h0064 + 16'(s);
			ticks(2);
			bus(1'b0, ADDR_STATUS, 32'h0000_0000);
			chk(32'(rdat[ST_ERR_LSB + F_OVERDRIVE]), 32'(s));
		end
		step <= 16'h0000;
		chk(32'(tally), 32'h0000_0000);
		$display("window test done");
	endtask
	task t_actions;
		logic [15:0] map, prev;
		logic [1:0] e;
		prev = MAP_RESET;
		for (int f = 3; f < 8; f += 4) begin
			for (int c = 0; c < 4; c++) begin
				map = (16'(c[0]) << (MAP_SOFT_LSB + f)) | (16'(c[1]) << f);
				e = (c == 0 && f == F_ENC_FAULT) ? 2'b01 : 2'(c);
				wrr(ADDR_ACTION_MAP, 32'(map));
				rdr(ADDR_ACTIVE_MAP, 32'(prev));
				wrr(ADDR_CONTROL, 32'h0000_0017);
				rdr(ADDR_ACTIVE_MAP, 32'(map));
				prev = map;
				clr <= 1'b1;
				@(posedge clk);
				clr <= 1'b0;
				flt <= 8'h01 << f;
				// fault pins pass the synchroniser before the error word
				ticks(5);
				chk(32'(tally), 32'({1'b0, e == 2'b01 && f != F_ENC_FAULT,
					1'b0, e == 2'b01 && f == F_ENC_FAULT, 1'b0, e[1], 1'b0,
					e != 2'b00}));
				bus(1'b0, ADDR_STATUS, 32'h0000_0000);
				chk(32'({rdat[ST_HALT], rdat[ST_OPEN_LOOP], amp}),
					32'({e != 2'b00, e[1], e != 2'b11}));
				flt <= 8'h00;
				ticks(2);
			end
		end
		$display("action test done");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_scale();
		t_window();
		t_actions();
		finish_test();
	end
endmodule
